// ### hdl/tbf_cfg.svh
// Purpose: constants of the translation buffer with fault ranking
// Assumes: 8 KB pages, 43-bit virtual addresses, 32-bit frame numbers
// Notes: register byte offsets, page entry field positions, response codes
`ifndef TBF_CFG_SVH
`define TBF_CFG_SVH

`define TBF_VA_W 43
`define TBF_PAGE_BITS 13
`define TBF_VPN_W 30
`define TBF_PFN_W 32
`define TBF_PA_W 45
`define TBF_TAG_W 5
`define TBF_ADDR_W 8

`define TBF_REG_SPACE_TAG 8'h00
`define TBF_REG_INV_SINGLE 8'h04
`define TBF_REG_INV_ALL 8'h08
`define TBF_REG_INV_PROC 8'h0C
`define TBF_REG_CHECK_VPN 8'h10
`define TBF_REG_CHECK_RES 8'h14
`define TBF_REG_STATUS 8'h18

`define TBF_PTE_VALID 0
`define TBF_PTE_FO_READ 1
`define TBF_PTE_FO_WRITE 2
`define TBF_PTE_FO_EXEC 3
`define TBF_PTE_GLOBAL 4
`define TBF_PTE_KRE 8
`define TBF_PTE_WE_BASE 12
`define TBF_PTE_PFN_LO 32

`define TBF_RESP_OKAY 2'h0
`define TBF_RESP_SLVERR 2'h2
`define TBF_LEVEL_LAST 2'h3

`endif

// ### hdl/tbf_pkg.sv
// Purpose: types shared by the translation buffer files
// Assumes: widths from tbf_cfg.svh
// Notes: fault flags are one bit per distinct exception vector
`include "tbf_cfg.svh"
package tbf_pkg;
    typedef enum logic [1:0] {
        TBF_KERNEL = 2'h0,
        TBF_EXEC_MODE = 2'h1,
        TBF_SUPER = 2'h2,
        TBF_USER = 2'h3
    } tbf_mode_type;

    typedef enum logic [1:0] {
        TBF_READ = 2'h0,
        TBF_WRITE = 2'h1,
        TBF_FETCH = 2'h2
    } tbf_access_type;

    typedef enum logic [2:0] {
        TBF_IDLE = 3'h1,
        TBF_LOOK = 3'h2,
        TBF_WALK = 3'h4
    } tbf_state_type;

    typedef struct packed {
        logic access_violation_fault;
        logic translation_not_valid_fault;
        logic fo_read;
        logic fo_write;
        logic fo_exec;
    } tbf_fault_type;

    typedef struct packed {
        logic [`TBF_VA_W-1:0] va;
        tbf_access_type access;
        tbf_mode_type mode;
    } tbf_req_type;

    typedef struct packed {
        logic [`TBF_PA_W-1:0] pa;
        tbf_fault_type fault;
    } tbf_rsp_type;
endpackage

// ### hdl/tbf_fault_rank.sv
// Purpose: rank raw memory management faults into one reported fault
// Assumes: raw flags computed for a single access
// Notes: purely combinational
module tbf_fault_rank (
    // raw flags
    input wire tbf_pkg::tbf_fault_type raw,
    // ranked, at most one bit set
    output tbf_pkg::tbf_fault_type ranked
);
    import tbf_pkg::*;

    wire any_acv = raw.access_violation_fault;
    wire any_tnv = raw.translation_not_valid_fault & ~any_acv;
    wire bits_ok = ~raw.access_violation_fault & ~raw.translation_not_valid_fault;
    // read fault bit taken first when read and write both flag
    wire pick_rd = bits_ok & raw.fo_read;
    wire pick_wr = bits_ok & raw.fo_write & ~raw.fo_read;
    wire pick_ex = bits_ok & raw.fo_exec & ~raw.fo_read & ~raw.fo_write;

    // violation over all, not-valid over fault bits
    assign ranked = '{access_violation_fault: any_acv, translation_not_valid_fault: any_tnv, fo_read: pick_rd,
                      fo_write: pick_wr, fo_exec: pick_ex};
endmodule

// ### hdl/tbf_top.sv
// Purpose: fully associative translation buffer with fault classification
// Assumes: AXI4-Lite register access, external page-table walker
// Notes: one lookup at a time; invalidations may land in any cycle
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "tbf_cfg.svh"
module tbf_top #(
    parameter int ENTRIES = 8,
    parameter int TAG_W = `TBF_TAG_W,
    parameter bit ASN_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pipeline lookup
    input wire logic req_valid,
    output logic req_ready,
    input wire tbf_pkg::tbf_req_type req,
    output logic rsp_valid,
    output tbf_pkg::tbf_rsp_type rsp,
    // page-table walker
    output logic walk_req,
    output logic [`TBF_VA_W-1:0] walk_va,
    input wire logic walk_done,
    input wire logic [1:0] walk_level,
    input wire logic [63:0] walk_pte,
    // AXI4-Lite write
    input wire logic [`TBF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [`TBF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tbf_pkg::*;

    localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    // two codes reserved: one for global entries, one for empty slots
    localparam logic [TAG_W-1:0] TAG_EMPTY = '1;
    localparam logic [TAG_W-1:0] TAG_GLOBAL = TAG_EMPTY - 1'b1;
    localparam logic [TAG_W-1:0] HIGHEST_TAG = TAG_EMPTY - 3'h3;
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(ENTRIES - 1);

    // one entry per slot; the tag field also encodes empty and global
    logic [`TBF_VPN_W-1:0] ent_vpn [ENTRIES];
    logic [TAG_W-1:0] ent_tag [ENTRIES];
    logic [`TBF_PFN_W-1:0] ent_pfn [ENTRIES];
    logic [7:0] ent_prot [ENTRIES];
    logic [2:0] ent_fbit [ENTRIES];

    tbf_state_type state;
    tbf_req_type req_q;
    logic [TAG_W-1:0] cur_tag;
    logic [`TBF_VPN_W-1:0] chk_vpn;
    logic check_present;
    logic [IDX_W-1:0] repl_ptr;
    tbf_fault_type raw_fault;
    tbf_fault_type ranked_fault;

    function automatic logic tbf_match(input logic [`TBF_VPN_W-1:0] evpn,
                                       input logic [TAG_W-1:0] etag,
                                       input logic [`TBF_VPN_W-1:0] vpn,
                                       input logic [TAG_W-1:0] tag);
        tbf_match = (etag != TAG_EMPTY) && (evpn == vpn) &&
                    ((etag == TAG_GLOBAL) || (etag == tag));
    endfunction

    // protection byte: read enables in [3:0], write enables in [7:4]
    function automatic logic tbf_prot_ok(input logic [7:0] prot,
                                         input tbf_mode_type mode,
                                         input tbf_access_type acc);
        // fetch counts as read intent
        tbf_prot_ok = (acc == TBF_WRITE) ? prot[4 + 32'(mode)]
                                         : prot[32'(mode)];
    endfunction

    // ---------------- AXI4-Lite slave ----------------
    logic aw_held, w_held;
    logic [`TBF_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire wr_swap = wr_fire & (aw_addr_q == `TBF_REG_SPACE_TAG);
    wire wr_inv_one = wr_fire & (aw_addr_q == `TBF_REG_INV_SINGLE);
    wire wr_inv_all = wr_fire & (aw_addr_q == `TBF_REG_INV_ALL);
    wire wr_inv_proc = wr_fire & (aw_addr_q == `TBF_REG_INV_PROC);
    wire wr_chk = wr_fire & (aw_addr_q == `TBF_REG_CHECK_VPN);
    wire wr_known = wr_swap | wr_inv_one | wr_inv_all | wr_inv_proc | wr_chk;
    // without tag support a context swap acts as a process flush
    wire flush_proc = wr_inv_proc | (wr_swap & ~ASN_SUPPORT);
    wire any_inv = wr_inv_one | wr_inv_all | flush_proc;
    wire [`TBF_VPN_W-1:0] w_vpn = w_data_q[`TBF_VPN_W-1:0];

    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_tag = s_axi_araddr == `TBF_REG_SPACE_TAG;
    wire rd_chk = s_axi_araddr == `TBF_REG_CHECK_VPN;
    wire rd_res = s_axi_araddr == `TBF_REG_CHECK_RES;
    wire rd_sts = s_axi_araddr == `TBF_REG_STATUS;
    wire rd_wo = (s_axi_araddr == `TBF_REG_INV_SINGLE) |
                 (s_axi_araddr == `TBF_REG_INV_ALL) |
                 (s_axi_araddr == `TBF_REG_INV_PROC);
    wire [31:0] status_word = {14'h0, ~state[0], ASN_SUPPORT,
                               16'(HIGHEST_TAG)};
    wire [31:0] rd_word = rd_tag ? 32'(cur_tag) :
                          rd_chk ? 32'(chk_vpn) :
                          rd_res ? {31'h0, check_present} :
                          rd_sts ? status_word : 32'h0;
    wire rd_ok = rd_tag | rd_chk | rd_res | rd_sts | rd_wo;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TBF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `TBF_RESP_OKAY : `TBF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TBF_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `TBF_RESP_OKAY : `TBF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- buffer match ----------------
    wire [TAG_W-1:0] eff_tag = ASN_SUPPORT ? cur_tag : '0;
    wire [`TBF_VPN_W-1:0] lk_vpn = req_q.va[`TBF_VA_W-1:`TBF_PAGE_BITS];
    logic [ENTRIES-1:0] hit_lk, hit_chk, ent_valid, ent_glob, kill;
    for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
        assign hit_lk[i] = tbf_match(ent_vpn[i], ent_tag[i], lk_vpn, eff_tag);
        assign hit_chk[i] = tbf_match(ent_vpn[i], ent_tag[i], chk_vpn, eff_tag);
        assign ent_valid[i] = ent_tag[i] != TAG_EMPTY;
        assign ent_glob[i] = ent_tag[i] == TAG_GLOBAL;
        // single invalidate drops the page under every tag
        assign kill[i] = wr_inv_all | (flush_proc & ~ent_glob[i]) |
                         (wr_inv_one & (ent_vpn[i] == w_vpn));
    end

    logic [IDX_W-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_lk[i]) begin
                hit_idx = IDX_W'(i);
            end
        end
    end

    wire lk_hit = |hit_lk;
    wire in_look = state == TBF_LOOK;
    wire in_walk = state == TBF_WALK;
    wire walk_end = in_walk & walk_done;
    wire last_lvl = walk_level == `TBF_LEVEL_LAST;
    wire pte_v = walk_pte[`TBF_PTE_VALID];
    // never cache an invalid entry; a colliding flush forces a re-walk
    wire install = walk_end & last_lvl & pte_v & ~any_inv;

    // ---------------- fault classification ----------------
    wire [7:0] pte_prot = walk_pte[`TBF_PTE_WE_BASE+3:`TBF_PTE_KRE];
    wire [2:0] pte_fbit = walk_pte[`TBF_PTE_FO_EXEC:`TBF_PTE_FO_READ];
    wire [7:0] use_prot = in_look ? ent_prot[hit_idx] : pte_prot;
    wire [2:0] use_fbit = in_look ? ent_fbit[hit_idx] : pte_fbit;
    wire prot_bad = ~tbf_prot_ok(use_prot, req_q.mode, req_q.access);
    wire upper_bad = walk_end & ~last_lvl & ~pte_v;
    wire upper_acv = upper_bad & ~walk_pte[`TBF_PTE_KRE];
    wire leaf_chk = in_look | (walk_end & last_lvl);
    always_comb begin
        raw_fault.access_violation_fault = upper_acv | (leaf_chk & prot_bad);
        raw_fault.translation_not_valid_fault = upper_bad | (walk_end & last_lvl & ~pte_v);
        raw_fault.fo_read = leaf_chk & use_fbit[0] & (req_q.access == TBF_READ);
        raw_fault.fo_write = leaf_chk & use_fbit[1] & (req_q.access == TBF_WRITE);
        raw_fault.fo_exec = leaf_chk & use_fbit[2] & (req_q.access == TBF_FETCH);
    end

    tbf_fault_rank u_rank (
        .raw(raw_fault),
        .ranked(ranked_fault)
    );

    // a valid leaf goes back to lookup; a faulting walk answers now
    wire answer_hit = in_look & lk_hit;
    wire answer_walk = walk_end & ~(last_lvl & pte_v);
    wire [`TBF_PA_W-1:0] hit_pa = {ent_pfn[hit_idx], req_q.va[`TBF_PAGE_BITS-1:0]};
    wire req_take = req_valid & req_ready;
    wire tbf_state_type next_state =
        req_take ? TBF_LOOK :
        (in_look & ~lk_hit) ? TBF_WALK :
        (answer_hit | answer_walk) ? TBF_IDLE :
        walk_end ? TBF_LOOK : state;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= TBF_IDLE;
            req_ready <= 1'b1;
            req_q <= '0;
            rsp_valid <= 1'b0;
            rsp <= '0;
            walk_req <= 1'b0;
            walk_va <= '0;
        end else begin
            state <= next_state;
            req_ready <= next_state == TBF_IDLE;
            rsp_valid <= answer_hit | answer_walk;
            walk_req <= next_state == TBF_WALK;
            if (req_take) begin
                req_q <= req;
            end
            if (in_look & ~lk_hit) begin
                walk_va <= req_q.va;
            end
            if (answer_hit | answer_walk) begin
                rsp.pa <= answer_hit ? hit_pa : '0;
                rsp.fault <= ranked_fault;
            end
        end
    end

    // ---------------- context and check registers ----------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_tag <= '0;
            chk_vpn <= '0;
            check_present <= 1'b0;
            repl_ptr <= '0;
        end else begin
            if (wr_swap) begin
                cur_tag <= w_data_q[TAG_W-1:0];
            end
            if (wr_chk) begin
                chk_vpn <= w_vpn;
            end
            check_present <= |hit_chk;
            // round robin keeps a just-filled page from being the next victim
            if (install) begin
                repl_ptr <= (repl_ptr == LAST_IDX) ? '0 : repl_ptr + 1'b1;
            end
        end
    end

    // ---------------- entry storage ----------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_tag[i] <= TAG_EMPTY;
            end
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (kill[i]) begin
                    ent_tag[i] <= TAG_EMPTY;
                end else if (install && repl_ptr == IDX_W'(i)) begin
                    ent_tag[i] <= walk_pte[`TBF_PTE_GLOBAL] ? TAG_GLOBAL : eff_tag;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (install) begin
            ent_vpn[repl_ptr] <= walk_va[`TBF_VA_W-1:`TBF_PAGE_BITS];
            ent_pfn[repl_ptr] <= walk_pte[`TBF_PTE_PFN_LO+`TBF_PFN_W-1:`TBF_PTE_PFN_LO];
            ent_prot[repl_ptr] <= pte_prot;
            ent_fbit[repl_ptr] <= pte_fbit;
        end
    end

    // ---------------- assertions ----------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_miss;
        in_look && !lk_hit;
    endsequence
    sequence s_walk_fault;
        walk_req && walk_done && (walk_level != `TBF_LEVEL_LAST);
    endsequence

    a_whole_flush: assert property (wr_inv_all |=> ent_valid == '0)
        else $error("entry survived whole-buffer invalidate");
    a_proc_flush: assert property (wr_inv_proc |=> (ent_valid & ~ent_glob) == '0)
        else $error("non-global entry survived process invalidate");
    a_swap_flush: assert property ((wr_swap && !ASN_SUPPORT) |=>
        (ent_valid & ~ent_glob) == '0)
        else $error("context swap left non-global entry");
    a_no_bad_fill: assert property ((walk_end && !pte_v) |=>
        $countones(ent_valid) <= $countones($past(ent_valid)))
        else $error("invalid page entry was cached");
    a_miss_walks: assert property (s_miss |=> walk_req && walk_va == $past(req_q.va))
        else $error("miss did not start a walk");
    a_walk_fault: assert property (s_walk_fault |=> rsp_valid ##1 req_ready)
        else $error("upper-level fault not answered");
    a_hit_answer: assert property ((in_look && lk_hit) |=> rsp_valid ##1 !rsp_valid)
        else $error("hit not answered in one cycle");
    a_prot_fault: assert property ((in_look && lk_hit && prot_bad) |=>
        rsp.fault.access_violation_fault)
        else $error("protection violation not reported");
    a_acv_first: assert property ((rsp_valid && rsp.fault.access_violation_fault) |->
        !(rsp.fault.translation_not_valid_fault || rsp.fault.fo_read || rsp.fault.fo_write ||
          rsp.fault.fo_exec))
        else $error("fault ranked above access violation");
    a_one_vector: assert property (rsp_valid |-> $onehot0(rsp.fault))
        else $error("more than one fault vector");
    a_check_state: assert property ((in_look && lk_hit && (lk_vpn == chk_vpn)) |=>
        check_present)
        else $error("presence check disagrees with buffer");
endmodule

// ### dv/tbf_walker_model.sv
// Purpose: page-table walker model that answers translation buffer misses
// Assumes: one walk at a time, answer after a programmable number of cycles
// Notes: entry lines carry a changing pattern outside the answer cycle
module tbf_walker_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // walk handshake
    input wire logic walk_req,
    output logic walk_done,
    output logic [1:0] walk_level,
    output logic [63:0] walk_pte,
    // scenario setup
    input wire logic [63:0] cfg_pte,
    input wire logic [1:0] cfg_level,
    input wire logic [3:0] cfg_delay
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            walk_done <= 1'b0;
            wait_cnt <= 4'h0;
            walk_level <= 2'h0;
            walk_pte <= 64'h0;
        end else if (walk_req && !walk_done && wait_cnt == cfg_delay) begin
            // one entry per walk, only while asked
            walk_done <= 1'b1;
            walk_level <= cfg_level;
            walk_pte <= cfg_pte;
            wait_cnt <= 4'h0;
        end else begin
            walk_done <= 1'b0;
            walk_level <= ~walk_level;
            walk_pte <= ~walk_pte;
            wait_cnt <= (walk_req && !walk_done) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ### dv/translation_buffer_faults_tb_top.sv
// Purpose: self-checking bench for the translation buffer with fault ranking
// Assumes: walker model on the miss port, register access over AXI4-Lite
// Notes: each fault case starts from an empty buffer
`include "tbf_cfg.svh"
module translation_buffer_faults_tb_top;
    import tbf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, rsp_valid;
    tbf_req_type req = '0;
    tbf_rsp_type rsp;
    logic walk_req, walk_done;
    logic [42:0] walk_va, last_wva = '0;
    logic [1:0] walk_level, w_lvl = 2'h3;
    logic [63:0] walk_pte, w_pte = '0;
    logic [3:0] w_dly = 4'h0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0;
    logic [1:0] bresp, rresp, rs;
    int num_errors = 0, n_checks = 0, n_walks = 0, cyc = 0;
    localparam logic [15:0] FL [10] = '{16'h0000, 16'h0100, 16'hFF00, 16'h0F01, 16'h7701,
        16'hFF03, 16'hFF05, 16'hFF09, 16'h7700, 16'hFF02};
    localparam logic [1:0] LV [10] = '{1, 2, 3, 3, 3, 3, 3, 3, 3, 3};
    localparam logic [1:0] AC [10] = '{0, 0, 0, 1, 0, 0, 1, 2, 0, 0};
    localparam logic [1:0] MD [10] = '{0, 0, 0, 3, 3, 0, 0, 0, 3, 0};
    localparam logic [4:0] EX [10] = '{5'h10, 5'h08, 5'h08, 5'h10, 5'h10, 5'h04, 5'h02,
        5'h01, 5'h10, 5'h08};
    always #2 clk_sys = ~clk_sys;
    tbf_top DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .walk_req(walk_req), .walk_va(walk_va),
        .walk_done(walk_done), .walk_level(walk_level), .walk_pte(walk_pte),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    tbf_walker_model walker (.clk_sys(clk_sys), .rst(rst), .walk_req(walk_req),
        .walk_done(walk_done), .walk_level(walk_level), .walk_pte(walk_pte),
        .cfg_pte(w_pte), .cfg_level(w_lvl), .cfg_delay(w_dly));
    // copy without tag support: every context swap must flush its non-global entries
    tbf_top #(.ASN_SUPPORT(1'b0)) DUT_NOTAG (.clk_sys(clk_sys), .rst(rst),
        .req_valid(req_valid), .req_ready(), .req(req), .rsp_valid(), .rsp(),
        .walk_req(), .walk_va(), .walk_done(walk_done), .walk_level(walk_level),
        .walk_pte(walk_pte), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
        .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));
    always @(posedge clk_sys) begin
        cyc++;
        if (walk_done && walk_req) begin
            n_walks++;
            last_wva = walk_va;
        end
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_fault(input tbf_fault_type got, input logic [4:0] exp);
        check_word({59'h0, got}, {59'h0, exp});
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_on = 1'b1, w_on = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_on || w_on) begin
            @(posedge clk_sys);
            if (aw_on && awready) begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_on && wready) begin
                w_on = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        rs = bresp;
    endtask
    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
    endtask
    task automatic lookup(input logic [29:0] vpn, input logic [1:0] a, input logic [1:0] m);
        req_valid <= 1'b1;
        req <= '{va: {vpn, 13'h0ABC}, access: tbf_access_type'(a), mode: tbf_mode_type'(m)};
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk_sys); while (rsp_valid !== 1'b1);
    endtask
    task automatic present(input logic [29:0] vpn, input logic exp);
        axi_write(`TBF_REG_CHECK_VPN, {2'h0, vpn});
        repeat (2) @(posedge clk_sys);
        axi_read(`TBF_REG_CHECK_RES);
        check_word({32'h0, rd}, {63'h0, exp});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        axi_read(`TBF_REG_STATUS);
        check_word({32'h0, rd}, 64'h0001_001C);
        axi_read(8'h40);
        check_word({rd, 30'h0, rs}, 64'h2);
        axi_write(8'h40, 32'h0);
        check_word({62'h0, rs}, 64'h2);
        $display("test registers done");
        w_pte <= {32'h0000_0ABC, 16'h0, 16'hFF01};
        lookup(30'h11, 0, 0);
        check_word({19'h0, rsp.pa}, {19'h0, 32'h0ABC, 13'h0ABC});
        check_word({21'h0, last_wva}, {21'h0, 30'h11, 13'h0ABC});
        lookup(30'h11, 0, 0);
        check_word({19'h0, rsp.pa}, {19'h0, 32'h0ABC, 13'h0ABC});
        check_word(n_walks, 64'h1);
        axi_write(`TBF_REG_SPACE_TAG, 32'h3);
        present(30'h11, 1'b0);
        axi_write(`TBF_REG_SPACE_TAG, 32'h0);
        present(30'h11, 1'b1);
        w_dly <= 4'h6;
        w_pte <= {32'h0000_0ABC, 16'h0, 16'hFF11};
        lookup(30'h22, 0, 0);
        axi_write(`TBF_REG_INV_PROC, 32'h0);
        present(30'h22, 1'b1);
        present(30'h11, 1'b0);
        lookup(30'h11, 0, 0);
        axi_write(`TBF_REG_INV_SINGLE, 32'h11);
        present(30'h11, 1'b0);
        axi_write(`TBF_REG_INV_ALL, 32'h0);
        present(30'h22, 1'b0);
        $display("test buffer upkeep done");
        w_pte <= {32'h0000_0ABC, 16'h0, 16'hFF00};
        lookup(30'h33, 0, 0);
        present(30'h33, 1'b0);
        for (int i = 0; i < 10; i++) begin
            axi_write(`TBF_REG_INV_ALL, 32'h0);
            w_dly <= 4'(i);
            w_lvl <= LV[i];
            w_pte <= {32'h0000_0123, 16'h0, FL[i]};
            lookup(30'h44, AC[i], MD[i]);
            check_fault(rsp.fault, EX[i]);
        end
        $display("test fault ranking done");
        tally_and_finish();
    end
endmodule
